// *** src/bomap_pkg.sv ***
package bomap_pkg;

	// Program memory map
	localparam logic [15:0] PM_VEC_LAST = 16'h00ff;
	localparam logic [15:0] OPT_FIRST = 16'h003c;
	localparam logic [15:0] OPT_LAST = 16'h003f;
	localparam logic [15:0] OPT_A_ADDR = 16'h003e;
	localparam logic [15:0] OPT_B_ADDR = 16'h003f;
	localparam logic [15:0] VEC_NORMAL = 16'h0100;
	localparam logic [15:0] BOOT_BASE = 16'h0100;
	localparam logic [15:0] VEC_ALT_0 = 16'h0200;
	localparam logic [15:0] VEC_ALT_1 = 16'h0300;
	localparam logic [15:0] VEC_ALT_2 = 16'h0500;
	localparam logic [15:0] VEC_ALT_3 = 16'h0900;
	localparam logic [7:0] OPT_ERASED = 8'hff;

	// Option byte field positions
	localparam int OPT_VEC_CHG_BIT = 7;
	localparam int OPT_VEC_SEL_HI = 6;
	localparam int OPT_VEC_SEL_LO = 5;
	localparam int OPT_PROT_DIS_BIT = 2;
	localparam int OPT_PROT_SZ_HI = 1;
	localparam int OPT_PROT_SZ_LO = 0;
	localparam int OPT_WAKE_NORST_BIT = 0;

	// Register file map
	localparam logic [7:0] REG_UPPER_BASE = 8'hc0;
	localparam logic [7:0] REG_BANKED_BASE = 8'he0;
	localparam logic [7:0] REG_PAGE_SEL_ADDR = 8'hdf;
	localparam logic [7:0] REG_PAGE_SEL_RST = 8'h00;
	localparam logic [3:0] PAGE_ZERO = 4'h0;
	localparam logic [3:0] REG_BANK_B_HI = 4'h9;
	localparam int REG_IDX_W = 9;
	localparam int MAPPED_BANK_A = 27;
	localparam int MAPPED_BANK_B = 12;
	localparam int MAPPED_TOTAL = 39;
	localparam int WAKE_A_W = 8;
	localparam int WAKE_B_W = 4;

	typedef enum logic [2:0] {
		S_WAIT_A = 3'h0,
		S_CAP_A = 3'h1,
		S_WAIT_B = 3'h2,
		S_CAP_B = 3'h3,
		S_RUN = 3'h4
	} bomap_state_t;

	function automatic logic [15:0] bomap_alt_vec(input logic [1:0] sel);
		case (sel)
			2'h0: bomap_alt_vec = VEC_ALT_0;
			2'h1: bomap_alt_vec = VEC_ALT_1;
			2'h2: bomap_alt_vec = VEC_ALT_2;
			default: bomap_alt_vec = VEC_ALT_3;
		endcase
	endfunction

endpackage

// *** src/bomap_regmem.sv ***
`timescale 1ns/1ns
module bomap_regmem #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk_sys, // System clock
	input wire logic [AW-1:0] addr, // Physical register index
	input wire logic we, // Write strobe
	input wire logic [DW-1:0] wdata, // Write data
	input wire logic re, // Read strobe
	output logic [DW-1:0] rdata_q // Registered read data
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (re) begin
			rdata_q <= mem[addr];
		end
	end
endmodule

// *** src/bomap_wake_edge.sv ***
`timescale 1ns/1ns
module bomap_wake_edge #(
	parameter int N = 12
) (
	input wire logic clk_sys, // System clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic [N-1:0] pins, // Asynchronous wake pins
	output logic fall_q // Any falling edge seen, one cycle
);
	logic [N-1:0] sync1_q;
	logic [N-1:0] sync2_q;
	logic [N-1:0] prev_q;
	logic [N-1:0] fall_bit;

	// Pins idle high; reset to high so no edge is seen at release
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					sync1_q[i] <= 1'b1;
					sync2_q[i] <= 1'b1;
					prev_q[i] <= 1'b1;
				end else begin
					sync1_q[i] <= pins[i];
					sync2_q[i] <= sync1_q[i];
					prev_q[i] <= sync2_q[i];
				end
			end
			assign fall_bit[i] = prev_q[i] & ~sync2_q[i];
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fall_q <= 1'b0;
		end else begin
			fall_q <= |fall_bit;
		end
	end
endmodule

// *** src/bomap_top.sv ***
// Contract
// - Program memory path is 16 bits wide.
// - Register bus is 8 bits, address and data.
// - Locations 0h-0FFh are the vector area.
// - Locations 03Ch-03Fh hold startup option bytes.
// - Only option bytes 3Eh and 3Fh matter.
// - First fetch is 0100h unless redirected.
// - Erased options give vector 100h, no protection.
// - Bit 3Eh.7 low selects the boot vector.
// - With 3Eh.7 high, select bits are ignored.
// - Boot vector 0200h/0300h/0500h/0900h, sector follows; code takes sector end from 3Eh bits 1:0, not the vector select.
// - Protection on blocks erase/program in sector.
// - Bit 3Eh.2 high turns protection off.
// - Option 3Fh.0 low: wake also resets.
// - Falling edge on wake pins wakes stop; code also needs ext_int_en high and options loaded.
// - Option 3Fh.0 high: wake without reset.
// - Upper 64 bytes: separate direct, indirect areas.
// - Direct top 32 bytes banked, lower shared.
// - Reset selects upper bank a.
// - Mapped registers: 27 bank a, 12 bank b.
// - Page select register at DFh, bank a.
// - Page select nibbles: destination high, source low.
// - Reset clears both page select nibbles.
// - Only page 0 exists; software keeps it.
`timescale 1ns/1ns
module bomap_top
	import bomap_pkg::*;
(
	input wire logic clk_sys, // System clock, 25 MHz
	input wire logic reset, // Asynchronous reset, active high
	input wire logic [15:0] cpu_fetch_addr, // Core fetch address
	output logic cpu_hold_q, // Core must wait, options loading
	output logic [15:0] reset_vector_q, // First fetch address
	output logic [15:0] flash_addr_q, // Program memory read address
	input wire logic [7:0] flash_rdata, // Program memory data, 1 cycle
	output logic vec_area_q, // Fetch falls in vector area
	output logic opt_area_q, // Fetch falls on option bytes
	input wire logic flash_op_req, // Erase or program request pulse
	input wire logic flash_op_erase, // Request is an erase
	input wire logic [15:0] flash_op_addr, // Target of the request
	output logic flash_op_en_q, // Accepted request pulse
	output logic flash_op_erase_q, // Accepted request is an erase
	output logic [15:0] flash_op_addr_q, // Accepted target
	output logic flash_op_blocked_q, // Refused request pulse
	input wire logic stop_mode, // Core is in stop mode
	input wire logic ext_int_en, // External interrupts enabled
	input wire logic [WAKE_A_W-1:0] wake_port_a, // Wake pins, port a
	input wire logic [WAKE_B_W-1:0] wake_port_b_upper, // Wake pins, port b upper
	output logic stop_release_q, // End stop mode, pulse
	output logic wake_reset_q, // Wake reset request, pulse
	input wire logic [7:0] reg_bus, // Register bus, address or data
	input wire logic reg_addr_stb, // Bus holds an address
	input wire logic reg_indirect, // Address is indirect or indexed
	input wire logic reg_wr_stb, // Bus holds write data
	input wire logic reg_rd_stb, // Read at latched address
	output logic [7:0] reg_rdata_q, // Read data
	output logic reg_rvalid_q, // Read data valid pulse
	input wire logic choose_lower_bank_instr, // Select bank a
	input wire logic choose_upper_bank_instr, // Select bank b
	output logic bank_b_q, // Bank b selected
	output logic [7:0] register_page_select_q, // Page select register
	output logic page_invalid_q // Page select holds a nonzero page
);
	import bomap_pkg::*;

	bomap_state_t state_q;
	logic [7:0] opt_a_q;
	logic [7:0] opt_b_q;
	logic [15:0] vec_d;
	logic [15:0] prot_end;
	logic prot_hit;
	logic wake_fall_q;
	logic [7:0] reg_addr_q;
	logic reg_ind_q;
	logic [REG_IDX_W-1:0] reg_idx;
	logic page_hit;
	logic rd_pend_q;
	logic rd_page_q;
	logic [7:0] mem_rdata_q;

	// Option loader: two reads of the option bytes, then release the core
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= S_WAIT_A;
		end else begin
			case (state_q)
				S_WAIT_A: state_q <= S_CAP_A;
				S_CAP_A: state_q <= S_WAIT_B;
				S_WAIT_B: state_q <= S_CAP_B;
				S_CAP_B: state_q <= S_RUN;
				default: state_q <= S_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			opt_a_q <= OPT_ERASED;
			opt_b_q <= OPT_ERASED;
		end else if (state_q == S_CAP_A) begin
			opt_a_q <= flash_rdata;
		end else if (state_q == S_CAP_B) begin
			opt_b_q <= flash_rdata;
		end
	end

	always_comb begin
		if (opt_a_q[OPT_VEC_CHG_BIT]) begin
			vec_d = VEC_NORMAL;
		end else begin
			vec_d = bomap_alt_vec(opt_a_q[OPT_VEC_SEL_HI:OPT_VEC_SEL_LO]);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cpu_hold_q <= 1'b1;
			reset_vector_q <= VEC_NORMAL;
		end else if (state_q == S_CAP_B) begin
			cpu_hold_q <= 1'b0;
			reset_vector_q <= vec_d;
		end
	end

	// Fetch address path; the first fetch after loading is the vector
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flash_addr_q <= OPT_A_ADDR;
		end else if (state_q == S_CAP_A) begin
			flash_addr_q <= OPT_B_ADDR;
		end else if (state_q == S_CAP_B) begin
			flash_addr_q <= vec_d;
		end else if (state_q == S_RUN) begin
			flash_addr_q <= cpu_fetch_addr;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			vec_area_q <= 1'b0;
			opt_area_q <= 1'b0;
		end else begin
			vec_area_q <= (state_q == S_RUN) && (cpu_fetch_addr <= PM_VEC_LAST);
			opt_area_q <= (state_q == S_RUN) && (cpu_fetch_addr >= OPT_FIRST)
				&& (cpu_fetch_addr <= OPT_LAST);
		end
	end

	// Boot sector guard for erase and program
	assign prot_end = bomap_alt_vec(opt_a_q[OPT_PROT_SZ_HI:OPT_PROT_SZ_LO]);
	assign prot_hit = !opt_a_q[OPT_PROT_DIS_BIT] && (flash_op_addr >= BOOT_BASE)
		&& (flash_op_addr < prot_end);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flash_op_en_q <= 1'b0;
			flash_op_blocked_q <= 1'b0;
			flash_op_erase_q <= 1'b0;
			flash_op_addr_q <= 16'h0000;
		end else begin
			// Options are unknown until loaded, so refuse everything before
			flash_op_en_q <= flash_op_req && !cpu_hold_q && !prot_hit;
			flash_op_blocked_q <= flash_op_req && (cpu_hold_q || prot_hit);
			if (flash_op_req) begin
				flash_op_erase_q <= flash_op_erase;
				flash_op_addr_q <= flash_op_addr;
			end
		end
	end

	// Stop-mode wake from port a or port b upper pins
	bomap_wake_edge #(
		.N(WAKE_A_W + WAKE_B_W)
	) u_wake (
		.clk_sys(clk_sys),
		.reset(reset),
		.pins({wake_port_b_upper, wake_port_a}),
		.fall_q(wake_fall_q)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stop_release_q <= 1'b0;
			wake_reset_q <= 1'b0;
		end else begin
			stop_release_q <= wake_fall_q && stop_mode && ext_int_en && !cpu_hold_q;
			wake_reset_q <= wake_fall_q && stop_mode && ext_int_en && !cpu_hold_q
				&& !opt_b_q[OPT_WAKE_NORST_BIT];
		end
	end

	// Register bus: address phase latched, data phase uses it
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_addr_q <= 8'h00;
			reg_ind_q <= 1'b0;
		end else if (reg_addr_stb) begin
			reg_addr_q <= reg_bus;
			reg_ind_q <= reg_indirect;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bank_b_q <= 1'b0;
		end else if (choose_upper_bank_instr) begin
			bank_b_q <= 1'b1;
		end else if (choose_lower_bank_instr) begin
			bank_b_q <= 1'b0;
		end
	end

	always_comb begin
		if (reg_addr_q < REG_UPPER_BASE) begin
			reg_idx = {1'b0, reg_addr_q};
		end else if (reg_ind_q) begin
			reg_idx = {1'b0, reg_addr_q};
		end else if (bank_b_q && reg_addr_q >= REG_BANKED_BASE) begin
			reg_idx = {REG_BANK_B_HI, reg_addr_q[4:0]};
		end else begin
			reg_idx = {1'b1, reg_addr_q};
		end
	end

	assign page_hit = !reg_ind_q && (reg_addr_q == REG_PAGE_SEL_ADDR);

	bomap_regmem #(
		.AW(REG_IDX_W),
		.DW(8)
	) u_mem (
		.clk_sys(clk_sys),
		.addr(reg_idx),
		.we(reg_wr_stb),
		.wdata(reg_bus),
		.re(reg_rd_stb),
		.rdata_q(mem_rdata_q)
	);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			register_page_select_q <= REG_PAGE_SEL_RST;
			page_invalid_q <= 1'b0;
		end else if (reg_wr_stb && page_hit) begin
			register_page_select_q <= reg_bus;
			// Only page 0 exists; any other value is flagged, addressing stays page 0
			page_invalid_q <= (reg_bus[7:4] != PAGE_ZERO) || (reg_bus[3:0] != PAGE_ZERO);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_pend_q <= 1'b0;
			rd_page_q <= 1'b0;
			reg_rvalid_q <= 1'b0;
			reg_rdata_q <= 8'h00;
		end else begin
			rd_pend_q <= reg_rd_stb;
			rd_page_q <= page_hit;
			reg_rvalid_q <= rd_pend_q;
			if (rd_pend_q) begin
				reg_rdata_q <= rd_page_q ? register_page_select_q : mem_rdata_q;
			end
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_load_end;
		state_q == S_CAP_B ##1 state_q == S_RUN;
	endsequence

	sequence s_wake_cause;
		wake_fall_q && stop_mode && ext_int_en && !cpu_hold_q;
	endsequence

	property p_release;
		s_load_end |-> !cpu_hold_q && flash_addr_q == reset_vector_q;
	endproperty
	a_release: assert property (p_release) else $error("first fetch not at vector");

	property p_default_vec;
		!cpu_hold_q && opt_a_q[OPT_VEC_CHG_BIT] |-> reset_vector_q == VEC_NORMAL;
	endproperty
	a_default_vec: assert property (p_default_vec) else $error("normal vector wrong");

	property p_alt_vec;
		!cpu_hold_q && !opt_a_q[OPT_VEC_CHG_BIT] |->
			reset_vector_q == bomap_alt_vec(opt_a_q[OPT_VEC_SEL_HI:OPT_VEC_SEL_LO]);
	endproperty
	a_alt_vec: assert property (p_alt_vec) else $error("boot vector wrong");

	property p_opt_hold;
		!cpu_hold_q |=> $stable(opt_a_q) && $stable(opt_b_q) && $stable(reset_vector_q);
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("options changed after load");

	property p_prot_block;
		flash_op_req && !cpu_hold_q && !opt_a_q[OPT_PROT_DIS_BIT] && flash_op_addr >= BOOT_BASE
			&& flash_op_addr < prot_end |=> flash_op_blocked_q && !flash_op_en_q;
	endproperty
	a_prot_block: assert property (p_prot_block) else $error("protected op passed");

	property p_prot_off;
		flash_op_req && !cpu_hold_q && opt_a_q[OPT_PROT_DIS_BIT] |=> flash_op_en_q;
	endproperty
	a_prot_off: assert property (p_prot_off) else $error("unprotected op refused");

	property p_wake_rst;
		s_wake_cause and !opt_b_q[OPT_WAKE_NORST_BIT] |=> stop_release_q && wake_reset_q;
	endproperty
	a_wake_rst: assert property (p_wake_rst) else $error("wake without reset");

	property p_wake_norst;
		s_wake_cause and opt_b_q[OPT_WAKE_NORST_BIT] |=> stop_release_q && !wake_reset_q;
	endproperty
	a_wake_norst: assert property (p_wake_norst) else $error("wake raised reset");

	property p_bank;
		choose_lower_bank_instr && !choose_upper_bank_instr |=> !bank_b_q;
	endproperty
	a_bank: assert property (p_bank) else $error("bank a not selected");

	property p_page_hold;
		!(reg_wr_stb && page_hit) |=> $stable(register_page_select_q);
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page select changed");

	property p_read;
		reg_rd_stb && page_hit |-> ##2 reg_rvalid_q && reg_rdata_q == $past(register_page_select_q);
	endproperty
	a_read: assert property (p_read) else $error("page select readback wrong");

	property p_mapped;
		MAPPED_BANK_A + MAPPED_BANK_B == MAPPED_TOTAL;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped register count wrong");
endmodule

// *** tb/bomap_flash_model.sv ***
`timescale 1ns/1ns
module bomap_flash_model (
	input wire logic clk_sys, // System clock
	input wire logic [15:0] flash_addr_q, // Read address from the block
	input wire logic [7:0] opt_a, // Option byte at 3Eh
	input wire logic [7:0] opt_b, // Option byte at 3Fh
	output logic [7:0] flash_rdata // Read data, one cycle after the address
);
	// Unused option cells hold values that would upset the decode if read
	always_ff @(posedge clk_sys) begin
		case (flash_addr_q)
			16'h003c, 16'h003d: flash_rdata <= 8'h00;
			16'h003e: flash_rdata <= opt_a;
			16'h003f: flash_rdata <= opt_b;
			default: flash_rdata <= flash_addr_q[7:0] ^ flash_addr_q[15:8];
		endcase
	end
endmodule

// *** tb/boot_option_and_address_map_tb_top.sv ***
`timescale 1ns/1ns
module boot_option_and_address_map_tb_top;
	import bomap_pkg::*;
	logic clk_sys, reset, req, erase, stop_mode, ext_int_en, hold, vec_area, opt_area;
	logic addr_stb, indirect, wr_stb, rd_stb, lo_bank, hi_bank, op_en, op_erase, op_blocked;
	logic rel, wrst, rvalid, bank_b, page_inv;
	logic [15:0] fetch_addr, op_addr, flash_addr_q, vector, op_addr_q;
	logic [7:0] flash_rdata, reg_bus, rdata, page_q, opt_a, opt_b, wake_a;
	logic [3:0] wake_b;
	logic [15:0] vt [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
	logic [7:0] wpa [4] = '{8'hfe, 8'hf7, 8'hff, 8'hff};
	logic [3:0] wpb [4] = '{4'hf, 4'hf, 4'hb, 4'h7};
	int bad_count;
	int checked;
	int s;

	bomap_top uut (.clk_sys(clk_sys), .reset(reset), .cpu_fetch_addr(fetch_addr),
		.cpu_hold_q(hold), .reset_vector_q(vector), .flash_addr_q(flash_addr_q),
		.flash_rdata(flash_rdata), .vec_area_q(vec_area), .opt_area_q(opt_area),
		.flash_op_req(req), .flash_op_erase(erase), .flash_op_addr(op_addr),
		.flash_op_en_q(op_en), .flash_op_erase_q(op_erase), .flash_op_addr_q(op_addr_q),
		.flash_op_blocked_q(op_blocked), .stop_mode(stop_mode), .ext_int_en(ext_int_en),
		.wake_port_a(wake_a), .wake_port_b_upper(wake_b), .stop_release_q(rel),
		.wake_reset_q(wrst), .reg_bus(reg_bus), .reg_addr_stb(addr_stb),
		.reg_indirect(indirect), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb),
		.reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .choose_lower_bank_instr(lo_bank),
		.choose_upper_bank_instr(hi_bank), .bank_b_q(bank_b),
		.register_page_select_q(page_q), .page_invalid_q(page_inv));

	bomap_flash_model flash (.clk_sys(clk_sys), .flash_addr_q(flash_addr_q), .opt_a(opt_a),
		.opt_b(opt_b), .flash_rdata(flash_rdata));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [7:0] oa, input logic [7:0] ob);
		int n;
		@(posedge clk_sys);
		opt_a <= oa;
		opt_b <= ob;
		reset <= 1'b1;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		for (n = 0; n < 12; n++) begin
			@(posedge clk_sys);
			#1;
			if (hold === 1'b0) break;
		end
		if (n == 12) begin
			chk(16'h0001, 16'h0000);
			wrap_up();
		end
	endtask

	task automatic reg_addr(input logic [7:0] a, input logic ind);
		@(posedge clk_sys);
		reg_bus <= a;
		indirect <= ind;
		addr_stb <= 1'b1;
		@(posedge clk_sys);
		addr_stb <= 1'b0;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic ind, input logic [7:0] d);
		reg_addr(a, ind);
		reg_bus <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
		// A released bus shows the inverse, not the last data
		reg_bus <= ~d;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic ind, input logic [7:0] exp);
		int n;
		reg_addr(a, ind);
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		for (n = 0; n < 4; n++) begin
			#1;
			if (rvalid === 1'b1) break;
			@(posedge clk_sys);
		end
		if (n == 4) begin
			chk(16'h0001, 16'h0000);
			wrap_up();
		end
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic bank(input logic hi);
		@(posedge clk_sys);
		hi_bank <= hi;
		lo_bank <= !hi;
		@(posedge clk_sys);
		hi_bank <= 1'b0;
		lo_bank <= 1'b0;
		#1;
		chk({15'h0000, bank_b}, {15'h0000, hi});
	endtask

	task automatic fetch(input logic [15:0] a, input logic ev, input logic eo);
		@(posedge clk_sys);
		fetch_addr <= a;
		@(posedge clk_sys);
		#1;
		chk(flash_addr_q, a);
		chk({15'h0000, vec_area}, {15'h0000, ev});
		chk({15'h0000, opt_area}, {15'h0000, eo});
	endtask

	task automatic fop(input logic [15:0] a, input logic blk);
		@(posedge clk_sys);
		req <= 1'b1;
		op_addr <= a;
		erase <= a[0];
		@(posedge clk_sys);
		req <= 1'b0;
		#1;
		chk({15'h0000, op_blocked}, {15'h0000, blk});
		chk({15'h0000, op_en}, {15'h0000, !blk});
		chk(op_addr_q, a);
		chk({15'h0000, op_erase}, {15'h0000, a[0]});
	endtask

	task automatic wake(input logic [7:0] pa, input logic [3:0] pb, input logic en,
			input logic er, input logic ex);
		int n;
		logic got;
		logic rs;
		got = 1'b0;
		rs = 1'b0;
		@(posedge clk_sys);
		stop_mode <= 1'b1;
		ext_int_en <= en;
		wake_a <= pa;
		wake_b <= pb;
		for (n = 0; n < 10; n++) begin
			@(posedge clk_sys);
			#1;
			if (rel === 1'b1) begin
				got = 1'b1;
				rs = wrst;
			end
		end
		@(posedge clk_sys);
		stop_mode <= 1'b0;
		wake_a <= 8'hff;
		wake_b <= 4'hf;
		chk({15'h0000, got}, {15'h0000, er});
		chk({15'h0000, rs}, {15'h0000, ex});
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	initial begin
		bad_count = 0;
		checked = 0;
		reset = 1'b1;
		{req, erase, stop_mode, ext_int_en, addr_stb, indirect, wr_stb, rd_stb} = 8'h00;
		{lo_bank, hi_bank} = 2'b00;
		fetch_addr = 16'h0000;
		op_addr = 16'h0000;
		reg_bus = 8'h00;
		opt_a = 8'hff;
		opt_b = 8'hff;
		wake_a = 8'hff;
		wake_b = 4'hf;
		do_reset(8'hff, 8'hff);
		chk(vector, 16'h0100);
		chk({15'h0000, bank_b}, 16'h0000);
		chk({8'h00, page_q}, 16'h0000);
		fop(16'h0100, 1'b0);
		fetch(16'h003e, 1'b1, 1'b1);
		fetch(16'h003b, 1'b1, 1'b0);
		fetch(16'h00ff, 1'b1, 1'b0);
		fetch(16'hffff, 1'b0, 1'b0);
		reg_wr(8'hdf, 1'b0, 8'h35);
		reg_rd(8'hdf, 1'b0, 8'h35);
		chk({15'h0000, page_inv}, 16'h0001);
		reg_wr(8'hdf, 1'b1, 8'h00);
		reg_rd(8'hdf, 1'b0, 8'h35);
		reg_rd(8'hdf, 1'b1, 8'h00);
		reg_wr(8'hc5, 1'b0, 8'h5a);
		bank(1'b1);
		reg_rd(8'hc5, 1'b0, 8'h5a);
		reg_wr(8'he5, 1'b0, 8'h11);
		bank(1'b0);
		reg_wr(8'he5, 1'b0, 8'h22);
		reg_wr(8'he5, 1'b1, 8'h33);
		reg_rd(8'he5, 1'b0, 8'h22);
		reg_rd(8'he5, 1'b1, 8'h33);
		bank(1'b1);
		reg_rd(8'he5, 1'b0, 8'h11);
		wake(8'hfe, 4'hf, 1'b0, 1'b0, 1'b0);
		for (s = 0; s < 4; s++) begin
			do_reset({1'b0, s[1:0], 2'b11, 1'b0, s[1:0]}, {7'h7f, s[0]});
			chk({8'h00, page_q}, 16'h0000);
			chk({15'h0000, bank_b}, 16'h0000);
			chk(vector, vt[s]);
			chk(flash_addr_q, vt[s]);
			opt_a <= 8'hff;
			fop(vt[s] - 16'h0001, 1'b1);
			fop(vt[s], 1'b0);
			chk(vector, vt[s]);
			wake(wpa[s], wpb[s], 1'b1, 1'b1, !s[0]);
		end
		do_reset(8'he0, 8'hff);
		chk(vector, 16'h0100);
		fop(16'h0150, 1'b1);
		do_reset(8'h67, 8'hff);
		chk(vector, 16'h0900);
		fop(16'h0100, 1'b0);
		wrap_up();
	end
endmodule
